/* shared/capcmp_pkg.sv */
package capcmp_pkg;

    // Widths of the channel data paths.
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;

    // Stages of the pin synchroniser.
    localparam int PIN_SYNC_STAGES = 2;

    // Reset values of the channel registers.
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [7:0] READ_RESET = 8'h00;

    // Counter values that mark an overflow and an all-zero compare.
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Shared cycle length codes.
    localparam logic [1:0] CYCLE_LEN_8 = 2'h0;
    localparam logic [1:0] CYCLE_LEN_9 = 2'h1;
    localparam logic [1:0] CYCLE_LEN_10 = 2'h2;
    localparam logic [1:0] CYCLE_LEN_11 = 2'h3;

    // Counter masks for the 8 to 11 bit cycle lengths.
    localparam logic [15:0] CYCLE_MASK_8 = 16'h00ff;
    localparam logic [15:0] CYCLE_MASK_9 = 16'h01ff;
    localparam logic [15:0] CYCLE_MASK_10 = 16'h03ff;
    localparam logic [15:0] CYCLE_MASK_11 = 16'h07ff;

    // Operating modes of one channel.
    typedef enum logic [2:0] {
        MODE_CAPTURE,
        MODE_TIMER,
        MODE_HIGH_SPEED,
        MODE_FREQUENCY,
        MODE_PWM_SHORT,
        MODE_PWM_WIDE
    } chan_mode_t;

endpackage

/* src/pin_synchronizer.sv */
`timescale 1ns/1ps

module pin_synchronizer
    import capcmp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Asynchronous level in, synchronised level out.
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // The first stage is read only by the second stage.
    always_comb begin
        st_next = st_reg;
        st_next.first = level_in;
        st_next.second = st_reg.first;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.second;

endmodule

/* src/capture_compare_channel.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - A valid pin edge copies the counter into the compare register.
// - Rise and fall selects choose rising, falling or either edge.
// - Capture sets the sticky event flag; only software clears it.
// - Comparator and match enables set the flag on full equality.
// - Low byte write clears comparator enable; high byte write sets it.
// - High-speed mode inverts the pin on each match; match enable sets the flag.
// - High-speed mode with comparator off holds the pin level.
// - Frequency mode toggles on low byte match and adds the step.
// - A zero step in frequency mode means 256 counter clocks.
// - Frequency mode with match enable flags on full equality.
// - All short PWM channels share one cycle length select.
// - 8-bit PWM goes high on low byte match, low on overflow.
// - 8-bit PWM reloads the low byte from the high byte on rollover.
// - 8-bit PWM flags matches and signals overflow every 256 clocks.
// - Any PWM mode with comparator off drives the pin low.
// - Reload access select steers byte accesses to the reload register.
// - N-bit PWM high on match, low on bit N overflow with reload.
// - N-bit PWM overflow pulses every 512, 1024 or 2048 clocks.
// - 16-bit PWM flags matches and marks the counter wrap.
// - 16-bit PWM goes high on full match, low on 16-bit overflow.
module capture_compare_channel
    import capcmp_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Shared counter; count_tick marks a new counter value.
    input wire logic [15:0] counter_value,
    input wire logic count_tick,
    input wire logic [1:0] cycle_length_select,
    // Channel mode bits.
    input wire logic rise_capture_select,
    input wire logic fall_capture_select,
    input wire logic match_flag_enable,
    input wire logic toggle_enable,
    input wire logic pulse_mod_enable,
    input wire logic wide_pulse_mod_enable,
    input wire logic channel_irq_enable,
    input wire logic reload_access_select,
    input wire logic comparator_enable_write,
    input wire logic comparator_enable_wdata,
    // Byte access to the compare or reload register.
    input wire logic low_byte_write,
    input wire logic high_byte_write,
    input wire logic [7:0] write_byte,
    input wire logic flag_clear,
    // Channel pin.
    input wire logic channel_pin_in,
    output logic channel_pin_out,
    output logic channel_pin_oe,
    // Status and events.
    output logic channel_event_flag,
    output logic irq_request,
    output logic comparator_enable,
    output logic [7:0] read_low_byte,
    output logic [7:0] read_high_byte,
    output logic cycle_overflow_set,
    output logic counter_wrap_set
);

    typedef struct packed {
        logic [15:0] compare_word;
        logic [15:0] reload_word;
        logic comparator_enable;
        logic event_flag;
        logic irq;
        logic pin;
        logic pin_oe;
        logic prev_sample;
        logic [7:0] read_low;
        logic [7:0] read_high;
        logic cycle_ovf;
        logic wrap;
    } chan_state_t;

    chan_state_t st_reg;
    chan_state_t st_next;
    chan_mode_t mode;
    logic pin_sync;
    logic rise_edge;
    logic fall_edge;
    logic capture_evt;
    logic full_match;
    logic low_match;
    logic [15:0] cycle_mask;
    logic short_wrap;
    logic short_match;
    logic flag_set;

    pin_synchronizer #(
        .WIDTH(1)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .level_in(channel_pin_in),
        .level_out(pin_sync)
    );

    // Edge detection on consecutive synchronised samples.
    assign rise_edge = pin_sync && !st_reg.prev_sample;
    assign fall_edge = !pin_sync && st_reg.prev_sample;

    always_comb begin
        if (pulse_mod_enable && wide_pulse_mod_enable) begin
            mode = MODE_PWM_WIDE;
        end else if (pulse_mod_enable && toggle_enable) begin
            mode = MODE_FREQUENCY;
        end else if (pulse_mod_enable) begin
            mode = MODE_PWM_SHORT;
        end else if (toggle_enable) begin
            mode = MODE_HIGH_SPEED;
        end else if (match_flag_enable) begin
            mode = MODE_TIMER;
        end else begin
            mode = MODE_CAPTURE;
        end
    end

    // The shared select sets the cycle length of every short PWM channel.
    always_comb begin
        case (cycle_length_select)
            CYCLE_LEN_8: cycle_mask = CYCLE_MASK_8;
            CYCLE_LEN_9: cycle_mask = CYCLE_MASK_9;
            CYCLE_LEN_10: cycle_mask = CYCLE_MASK_10;
            CYCLE_LEN_11: cycle_mask = CYCLE_MASK_11;
            default: cycle_mask = CYCLE_MASK_8;
        endcase
    end

    assign capture_evt = (mode == MODE_CAPTURE)
        && ((rise_capture_select && rise_edge)
        || (fall_capture_select && fall_edge));
    assign full_match = count_tick && (counter_value == st_reg.compare_word);
    assign low_match = count_tick
        && (counter_value[7:0] == st_reg.compare_word[7:0]);
    assign short_wrap = count_tick && ((counter_value & cycle_mask) == WORD_ZERO);
    assign short_match = count_tick
        && ((counter_value & cycle_mask) == (st_reg.compare_word & cycle_mask));

    always_comb begin
        st_next = st_reg;
        flag_set = 1'b0;
        st_next.prev_sample = pin_sync;
        st_next.cycle_ovf = 1'b0;
        st_next.wrap = 1'b0;
        st_next.pin_oe = (mode != MODE_CAPTURE) && (mode != MODE_TIMER);
        case (mode)
            MODE_CAPTURE: begin
                if (capture_evt) begin
                    st_next.compare_word = counter_value;
                    flag_set = 1'b1;
                end
            end
            MODE_TIMER: begin
                flag_set = st_reg.comparator_enable && full_match;
            end
            MODE_HIGH_SPEED: begin
                if (st_reg.comparator_enable && full_match) begin
                    st_next.pin = !st_reg.pin;
                    flag_set = match_flag_enable;
                end
            end
            MODE_FREQUENCY: begin
                if (st_reg.comparator_enable && low_match) begin
                    st_next.pin = !st_reg.pin;
                    // A zero step lands on the same value 256 counts later.
                    st_next.compare_word[7:0] = 8'(st_reg.compare_word[7:0]
                        + st_reg.compare_word[15:8]);
                end
                flag_set = match_flag_enable && full_match;
            end
            MODE_PWM_SHORT: begin
                if (short_wrap && (cycle_length_select == CYCLE_LEN_8)) begin
                    st_next.compare_word[7:0] = st_reg.compare_word[15:8];
                    st_next.pin = st_reg.comparator_enable
                        && (st_reg.compare_word[15:8] == BYTE_ZERO);
                    st_next.cycle_ovf = 1'b1;
                    flag_set = match_flag_enable
                        && (st_reg.compare_word[15:8] == BYTE_ZERO);
                end else if (short_wrap) begin
                    st_next.compare_word = st_reg.reload_word;
                    st_next.pin = st_reg.comparator_enable
                        && ((st_reg.reload_word & cycle_mask) == WORD_ZERO);
                    st_next.cycle_ovf = 1'b1;
                    flag_set = match_flag_enable
                        && ((st_reg.reload_word & cycle_mask) == WORD_ZERO);
                end else if (short_match) begin
                    st_next.pin = st_reg.comparator_enable;
                    flag_set = match_flag_enable;
                end
                if (!st_reg.comparator_enable) begin
                    st_next.pin = 1'b0;
                end
            end
            MODE_PWM_WIDE: begin
                if (count_tick && (counter_value == WORD_ZERO)) begin
                    st_next.pin = st_reg.comparator_enable
                        && (st_reg.compare_word == WORD_ZERO);
                    st_next.wrap = 1'b1;
                    flag_set = match_flag_enable && full_match;
                end else if (full_match) begin
                    st_next.pin = st_reg.comparator_enable;
                    flag_set = match_flag_enable;
                end
                if (!st_reg.comparator_enable) begin
                    st_next.pin = 1'b0;
                end
            end
            default: begin
                st_next.pin = 1'b0;
            end
        endcase
        if (comparator_enable_write) begin
            st_next.comparator_enable = comparator_enable_wdata;
        end
        // Byte writes override a hardware update of the same byte in the same cycle.
        if (low_byte_write) begin
            st_next.comparator_enable = 1'b0;
            if (reload_access_select) begin
                st_next.reload_word[7:0] = write_byte;
            end else begin
                st_next.compare_word[7:0] = write_byte;
            end
        end
        if (high_byte_write) begin
            st_next.comparator_enable = 1'b1;
            if (reload_access_select) begin
                st_next.reload_word[15:8] = write_byte;
            end else begin
                st_next.compare_word[15:8] = write_byte;
            end
        end
        // A set in the clearing cycle wins.
        st_next.event_flag = (st_reg.event_flag && !flag_clear) || flag_set;
        st_next.irq = st_next.event_flag && channel_irq_enable;
        st_next.read_low = reload_access_select ? st_next.reload_word[7:0]
            : st_next.compare_word[7:0];
        st_next.read_high = reload_access_select ? st_next.reload_word[15:8]
            : st_next.compare_word[15:8];
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_reg.compare_word <= COMPARE_RESET;
            st_reg.reload_word <= RELOAD_RESET;
            st_reg.comparator_enable <= 1'b0;
            st_reg.event_flag <= 1'b0;
            st_reg.irq <= 1'b0;
            st_reg.pin <= 1'b0;
            st_reg.pin_oe <= 1'b0;
            st_reg.prev_sample <= 1'b0;
            st_reg.read_low <= READ_RESET;
            st_reg.read_high <= READ_RESET;
            st_reg.cycle_ovf <= 1'b0;
            st_reg.wrap <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign channel_pin_out = st_reg.pin;
    assign channel_pin_oe = st_reg.pin_oe;
    assign channel_event_flag = st_reg.event_flag;
    assign irq_request = st_reg.irq;
    assign comparator_enable = st_reg.comparator_enable;
    assign read_low_byte = st_reg.read_low;
    assign read_high_byte = st_reg.read_high;
    assign cycle_overflow_set = st_reg.cycle_ovf;
    assign counter_wrap_set = st_reg.wrap;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    chk_capture_load: assert property (capture_evt
        |=> st_reg.compare_word == $past(counter_value))
        else $error("capture did not load the counter value");
    chk_capture_edge_kind: assert property (capture_evt
        |-> (pin_sync != st_reg.prev_sample)
        && (pin_sync ? rise_capture_select : fall_capture_select))
        else $error("capture on an unselected edge");
    chk_flag_sticky: assert property (st_reg.event_flag && !flag_clear
        |=> st_reg.event_flag)
        else $error("event flag cleared without software");
    chk_capture_flag: assert property (capture_evt |=> st_reg.event_flag)
        else $error("capture did not set the event flag");
    chk_edge_two_samples: assert property (rise_edge
        |-> $past(channel_pin_in, 2) && !$past(channel_pin_in, 3))
        else $error("rising edge not from two synchronised samples");
    chk_timer_match_flag: assert property ((mode == MODE_TIMER)
        && st_reg.comparator_enable && full_match |=> st_reg.event_flag)
        else $error("timer match did not set the flag");
    chk_low_write_off: assert property (low_byte_write && !high_byte_write
        |=> !st_reg.comparator_enable)
        else $error("low byte write left the comparator on");
    chk_high_write_on: assert property (high_byte_write
        |=> st_reg.comparator_enable)
        else $error("high byte write left the comparator off");
    chk_hs_toggle: assert property ((mode == MODE_HIGH_SPEED)
        && st_reg.comparator_enable && full_match |=> st_reg.pin != $past(st_reg.pin))
        else $error("high-speed match did not toggle the pin");
    chk_hs_hold: assert property ((mode == MODE_HIGH_SPEED)
        && !st_reg.comparator_enable |=> st_reg.pin == $past(st_reg.pin))
        else $error("high-speed pin moved with comparator off");
    chk_freq_step: assert property ((mode == MODE_FREQUENCY)
        && st_reg.comparator_enable && low_match && !low_byte_write
        |=> st_reg.compare_word[7:0] == 8'($past(st_reg.compare_word[7:0])
        + $past(st_reg.compare_word[15:8])))
        else $error("frequency step not added");
    chk_pwm8_reload: assert property ((mode == MODE_PWM_SHORT)
        && (cycle_length_select == CYCLE_LEN_8) && short_wrap && !low_byte_write
        |=> st_reg.compare_word[7:0] == $past(st_reg.compare_word[15:8])
        && st_reg.cycle_ovf)
        else $error("8-bit rollover did not reload");
    chk_pwm_off_low: assert property (((mode == MODE_PWM_SHORT)
        || (mode == MODE_PWM_WIDE)) && !st_reg.comparator_enable |=> !st_reg.pin)
        else $error("PWM pin high with comparator off");
    chk_wide_wrap_low: assert property ((mode == MODE_PWM_WIDE)
        && count_tick && (counter_value == WORD_ZERO)
        && (st_reg.compare_word != WORD_ZERO) |=> !st_reg.pin && st_reg.wrap)
        else $error("16-bit overflow did not drive the pin low");

endmodule

/* testbench/pin_source.sv */
`timescale 1ns/1ps

// Outside source on the channel pin; every new level is held two clocks or more.
module pin_source (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Request for a new pin level.
    input wire logic move_req,
    input wire logic move_level,
    // Level driven onto the pin and readiness for the next change.
    output logic drive_level,
    output logic ready
);
    logic [1:0] hold_reg;

    assign ready = (hold_reg == 2'h0);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            drive_level <= 1'b0;
            hold_reg <= 2'h0;
        end else if (move_req && ready) begin
            drive_level <= move_level;
            hold_reg <= 2'h2;
        end else if (!ready) begin
            hold_reg <= hold_reg - 2'h1;
        end
    end
endmodule

/* testbench/counter_array_capture_compare_bench.sv */
`timescale 1ns/1ps

module counter_array_capture_compare_bench;
    import capcmp_pkg::*;
    logic sys_clk, reset, count_tick, rise, fall, match, tog, pwm, wide, irq_en, ras;
    logic low_wr, high_wr, flag_clear, move_req, move_level, drive_level, ready, pin_wire;
    logic [15:0] counter_value;
    logic [1:0] cyc_len;
    logic [7:0] write_byte, rd_low, rd_high;
    logic pin_out, pin_oe, flag, irq, ecom, ovf, wrap;
    logic ecom_wr, ecom_wd;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    assign pin_wire = pin_oe ? pin_out : drive_level;

    capture_compare_channel i_capture_compare_channel (
        .sys_clk(sys_clk), .reset(reset), .counter_value(counter_value),
        .count_tick(count_tick), .cycle_length_select(cyc_len),
        .rise_capture_select(rise), .fall_capture_select(fall),
        .match_flag_enable(match), .toggle_enable(tog), .pulse_mod_enable(pwm),
        .wide_pulse_mod_enable(wide), .channel_irq_enable(irq_en),
        .reload_access_select(ras), .comparator_enable_write(ecom_wr),
        .comparator_enable_wdata(ecom_wd), .low_byte_write(low_wr),
        .high_byte_write(high_wr), .write_byte(write_byte), .flag_clear(flag_clear),
        .channel_pin_in(pin_wire), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
        .channel_event_flag(flag), .irq_request(irq), .comparator_enable(ecom),
        .read_low_byte(rd_low), .read_high_byte(rd_high), .cycle_overflow_set(ovf),
        .counter_wrap_set(wrap)
    );

    pin_source i_pin_source (
        .sys_clk(sys_clk), .reset(reset), .move_req(move_req), .move_level(move_level),
        .drive_level(drive_level), .ready(ready)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic set_mode(input logic [5:0] m);
        @(posedge sys_clk);
        {rise, fall, match, tog, pwm, wide} <= m;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic hi, input logic [7:0] b);
        @(posedge sys_clk);
        high_wr <= hi;
        low_wr <= !hi;
        write_byte <= b;
        @(posedge sys_clk);
        high_wr <= 1'b0;
        low_wr <= 1'b0;
        #1;
    endtask

    task automatic clear_flag();
        @(posedge sys_clk);
        flag_clear <= 1'b1;
        @(posedge sys_clk);
        flag_clear <= 1'b0;
        #1;
    endtask

    task automatic set_ecom(input logic v);
        @(posedge sys_clk);
        ecom_wr <= 1'b1;
        ecom_wd <= v;
        @(posedge sys_clk);
        ecom_wr <= 1'b0;
        #1;
    endtask

    task automatic tick_at(input logic [15:0] v);
        @(posedge sys_clk);
        counter_value <= v;
        count_tick <= 1'b1;
        @(posedge sys_clk);
        count_tick <= 1'b0;
        #1;
    endtask

    // Moves the pin, lets the synchroniser settle and judges the capture.
    task automatic pin_step(input logic lv, input logic [15:0] cnt, input logic hit,
                            input logic [7:0] exp_low, input logic [7:0] exp_high);
        int n;
        clear_flag();
        @(posedge sys_clk);
        counter_value <= cnt;
        move_req <= 1'b1;
        move_level <= lv;
        @(posedge sys_clk);
        move_req <= 1'b0;
        for (n = 0; n < 20 && !ready; n++) @(posedge sys_clk);
        repeat (6) @(posedge sys_clk);
        #1;
        chk_bit("capture flag", hit, flag);
        chk_bit("capture irq", hit, irq);
        chk_byte("capture low", exp_low, rd_low);
        chk_byte("capture high", exp_high, rd_high);
    endtask

    task automatic test_capture();
        @(posedge sys_clk);
        irq_en <= 1'b1;
        set_mode(6'b100000);
        pin_step(1'b1, 16'h1234, 1'b1, 8'h34, 8'h12);
        pin_step(1'b0, 16'h5678, 1'b0, 8'h34, 8'h12);
        set_mode(6'b010000);
        pin_step(1'b1, 16'h5678, 1'b0, 8'h34, 8'h12);
        pin_step(1'b0, 16'h9abc, 1'b1, 8'hbc, 8'h9a);
        set_mode(6'b110000);
        pin_step(1'b1, 16'hdef0, 1'b1, 8'hf0, 8'hde);
        pin_step(1'b0, 16'h0f1e, 1'b1, 8'h1e, 8'h0f);
        repeat (4) @(posedge sys_clk);
        #1;
        chk_bit("flag sticky", 1'b1, flag);
    endtask

    task automatic test_timer_fast();
        clear_flag();
        set_mode(6'b001000);
        wr(1'b0, 8'h02);
        chk_bit("ecom after low", 1'b0, ecom);
        wr(1'b1, 8'h01);
        chk_bit("ecom after high", 1'b1, ecom);
        tick_at(16'h0101);
        chk_bit("timer miss", 1'b0, flag);
        tick_at(16'h0102);
        chk_bit("timer hit", 1'b1, flag);
        tick_at(16'h0103);
        chk_bit("timer sticky", 1'b1, flag);
        clear_flag();
        set_mode(6'b001100);
        chk_bit("fast oe", 1'b1, pin_oe);
        tick_at(16'h0102);
        chk_bit("fast toggle", 1'b1, pin_out);
        chk_bit("fast flag", 1'b1, flag);
        wr(1'b0, 8'h02);
        tick_at(16'h0102);
        chk_bit("fast hold", 1'b1, pin_out);
        wr(1'b1, 8'h01);
        tick_at(16'h0102);
        chk_bit("fast toggle back", 1'b0, pin_out);
    endtask

    task automatic test_frequency();
        clear_flag();
        set_mode(6'b000110);
        wr(1'b0, 8'h10);
        wr(1'b1, 8'h20);
        tick_at(16'h0010);
        chk_bit("freq toggle", 1'b1, pin_out);
        chk_byte("freq step", 8'h30, rd_low);
        tick_at(16'h0030);
        chk_bit("freq toggle back", 1'b0, pin_out);
        chk_byte("freq step two", 8'h50, rd_low);
        wr(1'b1, 8'h00);
        tick_at(16'h0050);
        chk_bit("freq zero step pin", 1'b1, pin_out);
        chk_byte("freq zero step", 8'h50, rd_low);
        chk_bit("freq no flag", 1'b0, flag);
        set_mode(6'b001110);
        tick_at(16'h0050);
        chk_bit("freq full match flag", 1'b1, flag);
        chk_bit("freq toggle again", 1'b0, pin_out);
    endtask

    task automatic test_pwm();
        set_mode(6'b000010);
        wr(1'b0, 8'h40);
        wr(1'b1, 8'h80);
        tick_at(16'h0040);
        chk_bit("pwm8 rise", 1'b1, pin_out);
        tick_at(16'h0100);
        chk_bit("pwm8 fall", 1'b0, pin_out);
        chk_byte("pwm8 reload", 8'h80, rd_low);
        chk_bit("pwm8 ovf", 1'b1, ovf);
        @(posedge sys_clk);
        #1;
        chk_bit("pwm8 ovf pulse", 1'b0, ovf);
        tick_at(16'h0180);
        chk_bit("pwm8 rise reload", 1'b1, pin_out);
        wr(1'b0, 8'h80);
        tick_at(16'h0280);
        chk_bit("pwm ecom off", 1'b0, pin_out);
        @(posedge sys_clk);
        cyc_len <= CYCLE_LEN_9;
        wr(1'b0, 8'h80);
        wr(1'b1, 8'h01);
        @(posedge sys_clk);
        ras <= 1'b1;
        wr(1'b0, 8'h20);
        wr(1'b1, 8'h00);
        chk_byte("reload low", 8'h20, rd_low);
        chk_byte("reload high", 8'h00, rd_high);
        @(posedge sys_clk);
        ras <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk_byte("compare low", 8'h80, rd_low);
        chk_byte("compare high", 8'h01, rd_high);
        tick_at(16'h0180);
        chk_bit("pwm9 rise", 1'b1, pin_out);
        tick_at(16'h0300);
        chk_bit("pwm9 no ovf at byte", 1'b0, ovf);
        tick_at(16'h0400);
        chk_bit("pwm9 fall", 1'b0, pin_out);
        chk_bit("pwm9 ovf", 1'b1, ovf);
        chk_byte("pwm9 reload", 8'h20, rd_low);
    endtask

    task automatic test_pwm16();
        clear_flag();
        set_mode(6'b001011);
        wr(1'b0, 8'h00);
        wr(1'b1, 8'h80);
        tick_at(16'h8000);
        chk_bit("pwm16 rise", 1'b1, pin_out);
        chk_bit("pwm16 flag", 1'b1, flag);
        tick_at(16'hffff);
        chk_bit("pwm16 no wrap", 1'b0, wrap);
        tick_at(16'h0000);
        chk_bit("pwm16 fall", 1'b0, pin_out);
        chk_bit("pwm16 wrap", 1'b1, wrap);
        set_ecom(1'b0);
        chk_bit("ecom by write", 1'b0, ecom);
        tick_at(16'h8000);
        chk_bit("pwm16 off low", 1'b0, pin_out);
    endtask

    initial begin
        reset = 1'b1;
        {rise, fall, match, tog, pwm, wide} = 6'h00;
        {count_tick, irq_en, ras, low_wr, high_wr, flag_clear, move_req, move_level} = 8'h00;
        counter_value = 16'h0000;
        {ecom_wr, ecom_wd} = 2'h0;
        cyc_len = CYCLE_LEN_8;
        write_byte = 8'h00;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk_bit("reset flag", 1'b0, flag);
        chk_bit("reset ecom", 1'b0, ecom);
        chk_byte("reset low", READ_RESET, rd_low);
        test_capture();
        test_timer_fast();
        test_frequency();
        test_pwm();
        test_pwm16();
        give_verdict();
    end
endmodule
